// file: include/adc_win_pkg.sv
// Purpose: Shared constants and types for the converter window compare block
// Assumes: Byte-wide special-function register bus, one clock domain
// Notes: Channel codes between the third port and the sensors are reserved
`default_nettype none
package adc_win_pkg;
    // Register addresses on the special-function bus
    localparam logic [7:0] ADDR_INPUT_SELECT = 8'hbb;
    localparam logic [7:0] ADDR_WORD_LOW = 8'hbd;
    localparam logic [7:0] ADDR_WORD_HIGH = 8'hbe;
    localparam logic [7:0] ADDR_UPPER_LOW = 8'hc3;
    localparam logic [7:0] ADDR_UPPER_HIGH = 8'hc4;
    localparam logic [7:0] ADDR_LOWER_LOW = 8'hc5;
    localparam logic [7:0] ADDR_LOWER_HIGH = 8'hc6;
    localparam logic [7:0] ADDR_CONTROL = 8'he8;
    // Reset values
    localparam logic [7:0] RST_INPUT_SELECT = 8'h1f;
    localparam logic [7:0] RST_UPPER_BYTE = 8'hff;
    localparam logic [7:0] RST_LOWER_BYTE = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    // Field positions
    localparam int CHAN_MSB = 4;
    localparam int CTRL_FLAG_BIT = 3;
    localparam int CTRL_LEFT_BIT = 2;
    localparam int RAW_WIDTH = 10;
    localparam int WORD_WIDTH = 16;
    localparam int LEFT_SHIFT = 6;
    // Channel code landmarks
    localparam logic [4:0] CODE_LAST_LOW_PORTS = 5'h0f;
    localparam logic [4:0] CODE_LAST_PORT2 = 5'h16;
    localparam logic [4:0] CODE_TEMP = 5'h1b;
    localparam logic [4:0] CODE_VBAT = 5'h1c;
    localparam logic [4:0] CODE_VREG = 5'h1d;
    localparam logic [4:0] CODE_VDD = 5'h1e;
    localparam logic [4:0] CODE_GND = 5'h1f;
    // What the positive input is connected to
    typedef enum logic [2:0] {
        KIND_PORT_PIN = 3'h0,
        KIND_TEMP = 3'h1,
        KIND_VBAT = 3'h2,
        KIND_VREG = 3'h3,
        KIND_VDD = 3'h4,
        KIND_GND = 3'h5,
        KIND_NONE = 3'h6
    } channel_kind_t;
endpackage
`default_nettype wire

// file: src/window_compare.sv
// Purpose: Window test of one conversion word against two limits
// Assumes: Word and limits share one justification
// Notes: Pure combinational; the caller registers the outcome
`default_nettype none
module window_compare #(
    parameter int WIDTH = 16
) (
    // Operands
    input wire logic [WIDTH-1:0] word_i,
    input wire logic [WIDTH-1:0] less_than_i,
    input wire logic [WIDTH-1:0] greater_than_i,
    // Outcome
    output logic hit_o,
    output logic inside_mode_o
);
    // Limit ordering alone picks the mode, no mode bit exists
    always_comb
    begin
        inside_mode_o = less_than_i > greater_than_i;
        if (inside_mode_o)
        begin
            hit_o = (word_i > greater_than_i) && (word_i < less_than_i);
        end
        else
        begin
            hit_o = (word_i < less_than_i) || (word_i > greater_than_i);
        end
    end
endmodule
`default_nettype wire

// file: src/channel_decode.sv
// Purpose: Turn the positive channel code into a source kind and pin index
// Assumes: Third port exists only when HAS_PORT2 is set
// Notes: Reserved codes and a missing third port both give no source
`default_nettype none
module channel_decode
    import adc_win_pkg::*;
#(
    parameter bit HAS_PORT2 = 1'b1
) (
    // Code in
    input wire logic [4:0] code_i,
    // Decoded source
    output adc_win_pkg::channel_kind_t kind_o,
    output logic [4:0] pin_o
);
    // Ports zero and one ascend first, then the third port
    always_comb
    begin
        pin_o = code_i;
        kind_o = KIND_NONE;
        if (code_i <= CODE_LAST_LOW_PORTS)
        begin
            kind_o = KIND_PORT_PIN;
        end
        else if (code_i <= CODE_LAST_PORT2)
        begin
            kind_o = HAS_PORT2 ? KIND_PORT_PIN : KIND_NONE;
        end
        else
        begin
            case (code_i)
                CODE_TEMP: kind_o = KIND_TEMP;
                CODE_VBAT: kind_o = KIND_VBAT;
                CODE_VREG: kind_o = KIND_VREG;
                CODE_VDD: kind_o = KIND_VDD;
                CODE_GND: kind_o = KIND_GND;
                default: kind_o = KIND_NONE;
            endcase
        end
        if (kind_o != KIND_PORT_PIN)
        begin
            pin_o = 5'h00;
        end
    end
endmodule
`default_nettype wire

// file: src/adc_window_ctrl.sv
// Purpose: Window detector limits, flag and positive input selector
// Assumes: Converter hands over a 10-bit raw result with a one-cycle strobe
// Notes: Register reads come back one cycle after the address is presented
//
// What this block does
// - Lower limit low byte, read/write, resets zero
// - Lower limit high byte, separate read/write
// - Inside mode flags strictly between limits
// - Outside mode flags strictly below or above
// - Limit ordering alone selects mode
// - Raw result is unsigned ten bits
// - Compare formatted word, either justification
// - Compare each new result, flag in control
// - Flag usable for interrupt and polling
// - Five-bit read/write channel field
// - Channel upper three bits read zero
// - Codes up to 01111 select ports 0-1
// - Third port codes, reserved select nothing
// - Sensor and supply codes reachable
// - Code 11111 is ground, reset value
`default_nettype none
module adc_window_ctrl
    import adc_win_pkg::*;
#(
    parameter bit HAS_PORT2 = 1'b1
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Special-function register bus
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic SFR_WR_I,
    input wire logic [7:0] SFR_WDATA_I,
    output logic [7:0] SFR_RDATA_O,
    // Converter result path
    input wire logic [adc_win_pkg::RAW_WIDTH-1:0] RAW_RESULT_I,
    input wire logic RESULT_VALID_I,
    // Window flag and analogue selector
    output logic WINDOW_FLAG_O,
    output logic [4:0] CHANNEL_CODE_O,
    output adc_win_pkg::channel_kind_t CHANNEL_KIND_O,
    output logic [4:0] CHANNEL_PIN_O
);
    import adc_win_pkg::*;

    // Address match, used by write decode and read mux
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
        hits = addr == target;
    endfunction

    logic [7:0] lower_low;
    logic [7:0] lower_high;
    logic [7:0] upper_low;
    logic [7:0] upper_high;
    logic [4:0] chan;
    logic left_justify;
    logic flag;
    logic [WORD_WIDTH-1:0] word;
    logic [7:0] rdata;
    channel_kind_t kind;
    logic [4:0] pin;
    logic [7:0] next_lower_low;
    logic [7:0] next_lower_high;
    logic [7:0] next_upper_low;
    logic [7:0] next_upper_high;
    logic [4:0] next_chan;
    logic next_left_justify;
    logic next_flag;
    logic [WORD_WIDTH-1:0] next_word;
    logic [7:0] next_rdata;
    logic [WORD_WIDTH-1:0] formatted;
    logic [WORD_WIDTH-1:0] less_than_compare_value;
    logic [WORD_WIDTH-1:0] greater_than_compare_value;
    logic hit;
    logic inside_mode;
    channel_kind_t dec_kind;
    logic [4:0] dec_pin;
    logic [7:0] ctrl_read;

    assign less_than_compare_value = {lower_high, lower_low};
    assign greater_than_compare_value = {upper_high, upper_low};

    // Unsigned raw value placed right or left; limits use the same format
    always_comb
    begin
        formatted = {{LEFT_SHIFT{1'b0}}, RAW_RESULT_I};
        if (left_justify)
        begin
            formatted = {RAW_RESULT_I, {LEFT_SHIFT{1'b0}}};
        end
    end

    window_compare #(
        .WIDTH(WORD_WIDTH)
    ) u_compare (
        .word_i(formatted),
        .less_than_i(less_than_compare_value),
        .greater_than_i(greater_than_compare_value),
        .hit_o(hit),
        .inside_mode_o(inside_mode)
    );

    channel_decode #(
        .HAS_PORT2(HAS_PORT2)
    ) u_decode (
        .code_i(chan),
        .kind_o(dec_kind),
        .pin_o(dec_pin)
    );

    // Limit and selector writes; limits take effect byte by byte
    always_comb
    begin
        next_lower_low = lower_low;
        next_lower_high = lower_high;
        next_upper_low = upper_low;
        next_upper_high = upper_high;
        next_chan = chan;
        next_left_justify = left_justify;
        if (SFR_WR_I)
        begin
            if (hits(SFR_ADDR_I, ADDR_LOWER_LOW))
            begin
                next_lower_low = SFR_WDATA_I;
            end
            if (hits(SFR_ADDR_I, ADDR_LOWER_HIGH))
            begin
                next_lower_high = SFR_WDATA_I;
            end
            if (hits(SFR_ADDR_I, ADDR_UPPER_LOW))
            begin
                next_upper_low = SFR_WDATA_I;
            end
            if (hits(SFR_ADDR_I, ADDR_UPPER_HIGH))
            begin
                next_upper_high = SFR_WDATA_I;
            end
            if (hits(SFR_ADDR_I, ADDR_INPUT_SELECT))
            begin
                next_chan = SFR_WDATA_I[CHAN_MSB:0];
            end
            if (hits(SFR_ADDR_I, ADDR_CONTROL))
            begin
                next_left_justify = SFR_WDATA_I[CTRL_LEFT_BIT];
            end
        end
    end

    // Sticky window flag: writing 0 clears it, a new hit wins over the clear
    always_comb
    begin
        next_flag = flag;
        next_word = word;
        if (SFR_WR_I && hits(SFR_ADDR_I, ADDR_CONTROL) && !SFR_WDATA_I[CTRL_FLAG_BIT])
        begin
            next_flag = 1'b0;
        end
        if (RESULT_VALID_I)
        begin
            next_word = formatted;
            if (hit)
            begin
                next_flag = 1'b1;
            end
        end
    end

    // Read mux, registered so the bus sees data one cycle later
    always_comb
    begin
        ctrl_read = 8'h00;
        ctrl_read[CTRL_FLAG_BIT] = flag;
        ctrl_read[CTRL_LEFT_BIT] = left_justify;
        next_rdata = 8'h00;
        if (hits(SFR_ADDR_I, ADDR_LOWER_LOW))
        begin
            next_rdata = lower_low;
        end
        else if (hits(SFR_ADDR_I, ADDR_LOWER_HIGH))
        begin
            next_rdata = lower_high;
        end
        else if (hits(SFR_ADDR_I, ADDR_UPPER_LOW))
        begin
            next_rdata = upper_low;
        end
        else if (hits(SFR_ADDR_I, ADDR_UPPER_HIGH))
        begin
            next_rdata = upper_high;
        end
        else if (hits(SFR_ADDR_I, ADDR_INPUT_SELECT))
        begin
            next_rdata = {3'h0, chan};
        end
        else if (hits(SFR_ADDR_I, ADDR_CONTROL))
        begin
            next_rdata = ctrl_read;
        end
        else if (hits(SFR_ADDR_I, ADDR_WORD_LOW))
        begin
            next_rdata = word[7:0];
        end
        else if (hits(SFR_ADDR_I, ADDR_WORD_HIGH))
        begin
            next_rdata = word[15:8];
        end
    end

    // State registers
    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            lower_low <= RST_LOWER_BYTE;
            lower_high <= RST_LOWER_BYTE;
            upper_low <= RST_UPPER_BYTE;
            upper_high <= RST_UPPER_BYTE;
            chan <= RST_INPUT_SELECT[CHAN_MSB:0];
            left_justify <= RST_CONTROL[CTRL_LEFT_BIT];
            flag <= RST_CONTROL[CTRL_FLAG_BIT];
            word <= 16'h0000;
            rdata <= 8'h00;
            kind <= KIND_GND;
            pin <= 5'h00;
        end
        else
        begin
            lower_low <= next_lower_low;
            lower_high <= next_lower_high;
            upper_low <= next_upper_low;
            upper_high <= next_upper_high;
            chan <= next_chan;
            left_justify <= next_left_justify;
            flag <= next_flag;
            word <= next_word;
            rdata <= next_rdata;
            kind <= dec_kind;
            pin <= dec_pin;
        end
    end

    // Outputs straight from flip-flops; kind and pin lag the code by one cycle
    assign SFR_RDATA_O = rdata;
    assign WINDOW_FLAG_O = flag;
    assign CHANNEL_CODE_O = chan;
    assign CHANNEL_KIND_O = kind;
    assign CHANNEL_PIN_O = pin;

    // Checks on the flag, limits and selector
    chk_flag_sets_inside: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        RESULT_VALID_I && inside_mode && formatted > greater_than_compare_value
        && formatted < less_than_compare_value |=> WINDOW_FLAG_O)
        else $error("inside hit did not raise flag");
    chk_flag_sets_outside: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        RESULT_VALID_I && !inside_mode && (formatted < less_than_compare_value
        || formatted > greater_than_compare_value) |=> WINDOW_FLAG_O)
        else $error("outside hit did not raise flag");
    chk_mode_by_order: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        inside_mode == (less_than_compare_value > greater_than_compare_value))
        else $error("mode not set by limit order");
    chk_flag_rises_cause: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        $rose(WINDOW_FLAG_O) |-> $past(RESULT_VALID_I) && $past(hit))
        else $error("flag rose without a hit");
    chk_flag_holds: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        WINDOW_FLAG_O && !(SFR_WR_I && SFR_ADDR_I == ADDR_CONTROL) |=> WINDOW_FLAG_O)
        else $error("flag dropped without clear");
    chk_lower_low_write: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        SFR_WR_I && SFR_ADDR_I == ADDR_LOWER_LOW ##1 SFR_ADDR_I == ADDR_LOWER_LOW
        |=> SFR_RDATA_O == $past(SFR_WDATA_I, 2))
        else $error("lower low byte readback wrong");
    chk_select_upper_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        $past(SFR_ADDR_I) == ADDR_INPUT_SELECT |-> SFR_RDATA_O[7:5] == 3'h0)
        else $error("selector upper bits not zero");
    chk_select_write: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        SFR_WR_I && SFR_ADDR_I == ADDR_INPUT_SELECT |=> CHANNEL_CODE_O == $past(SFR_WDATA_I[4:0]))
        else $error("selector write lost");
    chk_ground_kind: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        CHANNEL_CODE_O == CODE_GND && $stable(CHANNEL_CODE_O) |=> CHANNEL_KIND_O == KIND_GND)
        else $error("ground code not decoded");
    // Mode, clear, decode and justification checks
    chk_mode_no_bit: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        $stable(less_than_compare_value) && $stable(greater_than_compare_value)
        |-> $stable(inside_mode))
        else $error("mode changed with limits unchanged");
    chk_flag_clears: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        SFR_WR_I && SFR_ADDR_I == ADDR_CONTROL && !SFR_WDATA_I[CTRL_FLAG_BIT]
        && !RESULT_VALID_I |=> !WINDOW_FLAG_O)
        else $error("flag clear write ignored");
    chk_low_ports_pin: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        CHANNEL_CODE_O <= CODE_LAST_LOW_PORTS && $stable(CHANNEL_CODE_O)
        |=> CHANNEL_KIND_O == KIND_PORT_PIN && CHANNEL_PIN_O == $past(CHANNEL_CODE_O))
        else $error("low port code not routed to its pin");
    chk_left_word: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        RESULT_VALID_I && left_justify |=> word == {$past(RAW_RESULT_I), {LEFT_SHIFT{1'b0}}})
        else $error("left justified word misplaced");
    cov_inside_hit: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        RESULT_VALID_I && inside_mode && hit);
    cov_outside_hit: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        RESULT_VALID_I && !inside_mode && hit);
    cov_set_over_clear: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        RESULT_VALID_I && hit && SFR_WR_I && SFR_ADDR_I == ADDR_CONTROL);
    cov_left_inside_hit: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
        RESULT_VALID_I && left_justify && inside_mode && hit);
endmodule
`default_nettype wire

// file: dv/conv_source.sv
// Purpose: Converter result source feeding the window block
// Assumes: Results launch on falling edges with a one-cycle strobe
// Notes: Idle result lines carry the inverse of the last word
`default_nettype none
module conv_source
    import adc_win_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Result path
    output logic [adc_win_pkg::RAW_WIDTH-1:0] raw_o,
    output logic valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet lines at time zero
    initial
    begin
        raw_o = '0;
        valid_o = 1'b0;
    end
    // One unsigned ten-bit result after an optional idle gap
    task automatic send(input logic [RAW_WIDTH-1:0] value, input int gap);
        repeat (gap) @(negedge clk_i);
        @(negedge clk_i);
        raw_o = value;
        valid_o = 1'b1;
        @(negedge clk_i);
        valid_o = 1'b0;
        // A stale word would hide sampling without the strobe
        raw_o = ~value;
    endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the window compare and channel selector
// Assumes: Register reads answer one cycle after the address edge
// Notes: Limits, flag and justification are mirrored in plain integers
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_win_pkg::*;
    // Design connections
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [RAW_WIDTH-1:0] raw;
    logic raw_valid;
    logic win_flag;
    logic [4:0] chan_code;
    channel_kind_t chan_kind;
    logic [4:0] chan_pin;
    channel_kind_t kind_small;
    logic [4:0] pin_small;
    // Bench model state
    int fails = 0;
    int comparisons = 0;
    int seed = 32'h31af;
    int m_lt = 0;
    int m_gt = 16'hffff;
    int m_flag = 0;
    int m_left = 0;
    int m_word = 0;
    int probes[$] = '{10'h000, 10'h03f, 10'h040, 10'h041, 10'h05f, 10'h060,
        10'h061, 10'h07f, 10'h080, 10'h081, 10'h3ff};
    int limits[3][2] = '{'{16'h0080, 16'h0040}, '{16'h0040, 16'h0080},
        '{16'h0060, 16'h0060}};
    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    adc_window_ctrl #(.HAS_PORT2(1'b1)) dut (
        .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .SFR_ADDR_I(sfr_addr), .SFR_WR_I(sfr_wr),
        .SFR_WDATA_I(sfr_wdata), .SFR_RDATA_O(sfr_rdata), .RAW_RESULT_I(raw),
        .RESULT_VALID_I(raw_valid), .WINDOW_FLAG_O(win_flag), .CHANNEL_CODE_O(chan_code),
        .CHANNEL_KIND_O(chan_kind), .CHANNEL_PIN_O(chan_pin)
    );
    conv_source conv (.clk_i(ref_clk), .raw_o(raw), .valid_o(raw_valid));
    // Variant without the third port on the same bus; only its decode is watched
    adc_window_ctrl #(.HAS_PORT2(1'b0)) dut_small (
        .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .SFR_ADDR_I(sfr_addr), .SFR_WR_I(sfr_wr),
        .SFR_WDATA_I(sfr_wdata), .SFR_RDATA_O(), .RAW_RESULT_I(raw),
        .RESULT_VALID_I(raw_valid), .WINDOW_FLAG_O(), .CHANNEL_CODE_O(),
        .CHANNEL_KIND_O(kind_small), .CHANNEL_PIN_O(pin_small)
    );
    // Comparison and verdict
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Register bus cycles; stale data is inverted so it cannot pass for fresh
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        sfr_addr = addr;
        sfr_wr = 1'b1;
        sfr_wdata = data;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
        sfr_wdata = ~data;
    endtask
    task automatic expect_reg(input string name, input logic [7:0] addr, input logic [7:0] exp);
        @(negedge ref_clk);
        sfr_addr = addr;
        @(negedge ref_clk);
        check(name, 16'(sfr_rdata), 16'(exp));
    endtask
    // Write and mirror into the model
    task automatic mwrite(input logic [7:0] addr, input logic [7:0] data);
        reg_write(addr, data);
        case (addr)
            ADDR_LOWER_LOW: m_lt = (m_lt & 16'hff00) | data;
            ADDR_LOWER_HIGH: m_lt = (m_lt & 16'h00ff) | (data << 8);
            ADDR_UPPER_LOW: m_gt = (m_gt & 16'hff00) | data;
            ADDR_UPPER_HIGH: m_gt = (m_gt & 16'h00ff) | (data << 8);
            ADDR_CONTROL:
            begin
                m_left = data[2];
                if (!data[3])
                    m_flag = 0;
            end
            default: ;
        endcase
    endtask
    function automatic int hit(input int w, input int lt, input int gt);
        if (lt > gt)
            return (w > gt && w < lt);
        return (w < lt || w > gt);
    endfunction
    function automatic channel_kind_t exp_kind(input int c);
        if (c <= 16'h16)
            return KIND_PORT_PIN;
        case (c)
            27: return KIND_TEMP;
            28: return KIND_VBAT;
            29: return KIND_VREG;
            30: return KIND_VDD;
            31: return KIND_GND;
            default: return KIND_NONE;
        endcase
    endfunction
    // One conversion, optionally after a flag clear
    task automatic sample(input logic [9:0] v, input bit clr);
        if (clr)
            mwrite(ADDR_CONTROL, 8'(m_left * 4));
        conv.send(v, int'(v[0]));
        m_word = m_left ? (v << 6) : v;
        if (hit(m_word, m_lt, m_gt))
            m_flag = 1;
        check("window flag", 16'(win_flag), 16'(m_flag));
        expect_reg("word low", ADDR_WORD_LOW, 8'(m_word));
        expect_reg("word high", ADDR_WORD_HIGH, 8'(m_word >> 8));
        expect_reg("control", ADDR_CONTROL, 8'(m_flag * 8 + m_left * 4));
    endtask
    // Main sequence
    initial
    begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        expect_reg("input select", ADDR_INPUT_SELECT, 8'h1f);
        expect_reg("lower low", ADDR_LOWER_LOW, 8'h00);
        expect_reg("lower high", ADDR_LOWER_HIGH, 8'h00);
        expect_reg("upper low", ADDR_UPPER_LOW, 8'hff);
        expect_reg("upper high", ADDR_UPPER_HIGH, 8'hff);
        expect_reg("unmapped", 8'h7a, 8'h00);
        check("channel kind", 16'(chan_kind), 16'(KIND_GND));
        mwrite(ADDR_LOWER_LOW, 8'h5c);
        mwrite(ADDR_LOWER_HIGH, 8'ha3);
        mwrite(ADDR_WORD_LOW, 8'h77);
        expect_reg("lower low", ADDR_LOWER_LOW, 8'h5c);
        expect_reg("lower high", ADDR_LOWER_HIGH, 8'ha3);
        expect_reg("word low", ADDR_WORD_LOW, 8'h00);
        // Every limit ordering in both justifications, boundaries first
        for (int left = 0; left < 2; left++)
            for (int m = 0; m < 3; m++)
            begin
                mwrite(ADDR_CONTROL, 8'(left * 4));
                mwrite(ADDR_CONTROL, 8'(8 + left * 4));
                // Both bytes go in before any result; left mode keeps low bytes zero
                mwrite(ADDR_LOWER_LOW, 8'((limits[m][0] << (6 * left))));
                mwrite(ADDR_LOWER_HIGH, 8'((limits[m][0] << (6 * left)) >> 8));
                mwrite(ADDR_UPPER_LOW, 8'((limits[m][1] << (6 * left))));
                mwrite(ADDR_UPPER_HIGH, 8'((limits[m][1] << (6 * left)) >> 8));
                foreach (probes[i])
                    sample(10'(probes[i]), 1'b1);
                repeat (4) sample(10'($random(seed)), 1'b0);
            end
        // Every channel code, passing ground before the sensor
        for (int c = 0; c < 32; c++)
        begin
            if (c == 27)
                mwrite(ADDR_INPUT_SELECT, 8'h1f);
            mwrite(ADDR_INPUT_SELECT, {3'($random(seed)), 5'(c)});
            expect_reg("input select", ADDR_INPUT_SELECT, 8'(c));
            check("channel code", 16'(chan_code), 16'(c));
            check("channel kind", 16'(chan_kind), 16'(exp_kind(c)));
            check("channel pin", 16'(chan_pin), 16'(c <= 16'h16 ? c : 0));
            check("kind no port2", 16'(kind_small),
                16'((c > 15 && c <= 16'h16) ? KIND_NONE : exp_kind(c)));
            check("pin no port2", 16'(pin_small), 16'(c <= 15 ? c : 0));
        end
        end_sim();
    end
    // Watchdog well past the expected run length
    initial
    begin
        #100000;
        fails++;
        end_sim();
    end
endmodule
`default_nettype wire
